// *** core/erab_regs.svh ***
// Purpose: Constants for the embedded RAM array block
// Assumes: 40 MHz ref_clk, AXI4-Lite register access
// Notes:   Offsets are byte addresses
//
// How it works
// - Address, data and control inputs and the read data are registered.
// - Array is preloaded over the bus, then locked read-only at the user port as a table; bus loads still write.
// - 256 words of 16 bits map any 8-bit input to any 16-bit output.
// - Word width is selectable from 1 to 16 bits for writes and reads.
// - Single-port shares the write address; dual-port reads separately.
// - Write and read sections each run on their own clock pulse in dual-port mode; single-port reads use the write pulse.
// - In dual-port mode each section has its own synchronous clock enable freezing only it; single-port uses wr_clk_en for both.
// - Input and output registers can each be bypassed.
// - Asynchronous clear forces the registered outputs to zero.
// - Separate write and read enables, registered or bypassed alike.
`ifndef ERAB_REGS_SVH
`define ERAB_REGS_SVH

// ==========================================================
// Geometry
`define ERAB_AW        8
`define ERAB_DW        16
`define ERAB_DEPTH     256
`define ERAB_WCW       4

// ==========================================================
// Register offsets
`define ERAB_OFS_CTRL  8'h00
`define ERAB_OFS_LADDR 8'h04
`define ERAB_OFS_LDATA 8'h08
`define ERAB_OFS_STAT  8'h0c

// ==========================================================
// Control fields
`define ERAB_CTRL_DUAL 0
`define ERAB_CTRL_IBYP 1
`define ERAB_CTRL_OBYP 2
`define ERAB_CTRL_LUT  3
`define ERAB_CTRL_WLO  8
`define ERAB_CTRL_WHI  11
`define ERAB_CTRL_RST  12'hf00

// ==========================================================
// Bus answers
`define ERAB_RESP_OK   2'h0
`define ERAB_RESP_ERR  2'h2

`endif

// *** core/erab_pkg.sv ***
// Purpose: Types for the embedded RAM array block
// Assumes: Used with erab_regs.svh
// Notes:   Nothing is imported
`include "erab_regs.svh"
package erab_pkg;
   typedef logic [`ERAB_AW-1:0] erab_addr_t;
   typedef logic [`ERAB_DW-1:0] erab_word_t;
   typedef enum logic {ERAB_SINGLE, ERAB_DUAL} erab_mode_t;
endpackage : erab_pkg

// *** core/erab_top.sv ***
// Purpose: Embedded RAM array block with registered ports and table mode
// Assumes: Section ticks and enables come from fabric logic on ref_clk
// Notes:   Array read is combinational between the two register stages
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "erab_regs.svh"
module erab_top (
   input  wire logic                  ref_clk,
   input  wire logic                  reset_n,
   input  wire logic                  clear_n,
   input  wire logic                  wr_tick,
   input  wire logic                  wr_clk_en,
   input  wire logic                  wr_en,
   input  wire erab_pkg::erab_addr_t  wr_addr,
   input  wire erab_pkg::erab_word_t  wr_data,
   input  wire logic                  rd_tick,
   input  wire logic                  rd_clk_en,
   input  wire logic                  rd_en,
   input  wire erab_pkg::erab_addr_t  rd_addr,
   output erab_pkg::erab_word_t       rd_data,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);

   // ==========================================================
   // Storage and control
   erab_pkg::erab_word_t  mem [`ERAB_DEPTH];
   logic [`ERAB_CTRL_WHI:0] ctrl_r;
   erab_pkg::erab_addr_t  laddr_r;
   erab_pkg::erab_mode_t  mode;
   logic                  ibyp;
   logic                  obyp;
   logic                  lut_on;
   erab_pkg::erab_word_t  wmask;
   logic                  arst_n;

   assign mode   = erab_pkg::erab_mode_t'(ctrl_r[`ERAB_CTRL_DUAL]);
   assign ibyp   = ctrl_r[`ERAB_CTRL_IBYP];
   assign obyp   = ctrl_r[`ERAB_CTRL_OBYP];
   assign lut_on = ctrl_r[`ERAB_CTRL_LUT];
   assign arst_n = reset_n & clear_n;

   function automatic erab_pkg::erab_word_t width_mask(input logic [`ERAB_WCW-1:0] wm1);
      width_mask = erab_pkg::erab_word_t'({1'b0, {`ERAB_DW{1'b1}}} >> (4'hf - wm1));
   endfunction : width_mask

   assign wmask = width_mask(ctrl_r[`ERAB_CTRL_WHI:`ERAB_CTRL_WLO]);

   // ==========================================================
   // Input registers
   logic                  wsec;
   logic                  rsec;
   logic                  wr_en_r;
   erab_pkg::erab_addr_t  wr_addr_r;
   erab_pkg::erab_word_t  wr_data_r;
   logic                  rd_en_r;
   erab_pkg::erab_addr_t  rd_addr_r;

   assign wsec = wr_tick & wr_clk_en;
   assign rsec = (mode == erab_pkg::ERAB_DUAL) ? (rd_tick & rd_clk_en) : wsec;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_en_r   <= 1'b0;
         wr_addr_r <= '0;
         wr_data_r <= '0;
      end
      else if (wsec)
      begin
         wr_en_r   <= wr_en;
         wr_addr_r <= wr_addr;
         wr_data_r <= wr_data;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rd_en_r   <= 1'b0;
         rd_addr_r <= '0;
      end
      else if (rsec)
      begin
         rd_en_r   <= rd_en;
         rd_addr_r <= rd_addr;
      end
   end

   // ==========================================================
   // Array write and read
   logic                  we_sel;
   erab_pkg::erab_addr_t  wa_sel;
   erab_pkg::erab_word_t  wd_sel;
   logic                  re_sel;
   erab_pkg::erab_addr_t  ra_sel;
   erab_pkg::erab_word_t  rd_comb;
   logic                  ld_we;
   erab_pkg::erab_word_t  ld_data;

   assign we_sel = ibyp ? wr_en : wr_en_r;
   assign wa_sel = ibyp ? wr_addr : wr_addr_r;
   assign wd_sel = ibyp ? wr_data : wr_data_r;
   assign re_sel = ibyp ? rd_en : rd_en_r;
   assign ra_sel = (mode == erab_pkg::ERAB_DUAL) ? (ibyp ? rd_addr : rd_addr_r) : wa_sel;
   assign rd_comb = mem[ra_sel] & wmask;

   always_ff @(posedge ref_clk)
   begin
      if (wsec && we_sel && !lut_on)
         mem[wa_sel] <= wd_sel & wmask;
      else if (ld_we)
         mem[laddr_r] <= ld_data;
   end

   // ==========================================================
   // Output register
   erab_pkg::erab_word_t  rd_q_r;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         rd_q_r <= '0;
      else if (rsec && re_sel)
         rd_q_r <= rd_comb;
   end

   assign rd_data = obyp ? (re_sel ? rd_comb : '0) : rd_q_r;

   // ==========================================================
   // AXI4-Lite write side
   logic                  aw_got_r;
   logic                  w_got_r;
   logic [7:0]            awaddr_r;
   logic [31:0]           wdata_r;
   logic                  bvalid_r;
   logic [1:0]            bresp_r;
   logic                  do_wr;

   assign s_axi_awready = !aw_got_r && !bvalid_r;
   assign s_axi_wready  = !w_got_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign do_wr   = aw_got_r && w_got_r && !bvalid_r;
   assign ld_we   = do_wr && (awaddr_r == `ERAB_OFS_LDATA);
   assign ld_data = wdata_r[`ERAB_DW-1:0];

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= '0;
         wdata_r  <= '0;
         bvalid_r <= 1'b0;
         bresp_r  <= `ERAB_RESP_OK;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
         end
         if (do_wr)
         begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r  <= (awaddr_r == `ERAB_OFS_CTRL || awaddr_r == `ERAB_OFS_LADDR ||
                         awaddr_r == `ERAB_OFS_LDATA) ? `ERAB_RESP_OK : `ERAB_RESP_ERR;
         end
         else if (bvalid_r && s_axi_bready)
            bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_r  <= `ERAB_CTRL_RST;
         laddr_r <= '0;
      end
      else if (do_wr)
      begin
         if (awaddr_r == `ERAB_OFS_CTRL)
            ctrl_r <= wdata_r[`ERAB_CTRL_WHI:0];
         else if (awaddr_r == `ERAB_OFS_LADDR)
            laddr_r <= wdata_r[`ERAB_AW-1:0];
         else if (ld_we)
            laddr_r <= laddr_r + erab_pkg::erab_addr_t'(1);
      end
   end

   // ==========================================================
   // AXI4-Lite read side
   logic                  rvalid_r;
   logic [31:0]           rdata_r;
   logic [1:0]            rresp_r;

   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= `ERAB_RESP_OK;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= `ERAB_RESP_OK;
         case (s_axi_araddr)
            `ERAB_OFS_CTRL:  rdata_r <= 32'(ctrl_r);
            `ERAB_OFS_LADDR: rdata_r <= 32'(laddr_r);
            `ERAB_OFS_LDATA: rdata_r <= 32'(mem[laddr_r]);
            `ERAB_OFS_STAT:  rdata_r <= 32'(rd_q_r);
            default:
            begin
               rdata_r <= '0;
               rresp_r <= `ERAB_RESP_ERR;
            end
         endcase
      end
      else if (rvalid_r && s_axi_rready)
         rvalid_r <= 1'b0;
   end

endmodule : erab_top

// *** bench/erab_monitor.sv ***
// Purpose: Port assertions for erab_top
// Assumes: ref_clk only, reset_n async low
// Notes:   Bound after endmodule
`timescale 1ns/1ps
module erab_monitor (
   input wire logic        ref_clk,
   input wire logic        reset_n,
   input wire logic [15:0] rd_data,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // =====
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   bresp_due_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("late bvalid");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write not blocked");
   rresp_due_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("late rvalid");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped");
   rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid stuck");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read not blocked");
   reset_out_a: assert property ($rose(reset_n) |-> rd_data == 16'h0)
      else $error("rd_data not cleared");
endmodule : erab_monitor

bind erab_top erab_monitor i_erab_monitor (
   .ref_clk       (ref_clk),
   .reset_n       (reset_n),
   .rd_data       (rd_data),
   .s_axi_awvalid (s_axi_awvalid),
   .s_axi_awready (s_axi_awready),
   .s_axi_wvalid  (s_axi_wvalid),
   .s_axi_wready  (s_axi_wready),
   .s_axi_bvalid  (s_axi_bvalid),
   .s_axi_bready  (s_axi_bready),
   .s_axi_arvalid (s_axi_arvalid),
   .s_axi_arready (s_axi_arready),
   .s_axi_rvalid  (s_axi_rvalid),
   .s_axi_rready  (s_axi_rready)
);

// *** bench/erab_fabric_model.sv ***
// Purpose: Fabric pacing of the two RAM sections
// Assumes: ref_clk domain
// Notes:   Read section ticks at half the write rate
`timescale 1ns/1ps
module erab_fabric_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   output logic     wr_tick,
   output logic     rd_tick
);
   // =====
   // Ticks
   logic [1:0] cnt_r;
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
         cnt_r <= 2'h0;
      else
         cnt_r <= cnt_r + 2'h1;
   assign wr_tick = cnt_r[0];
   assign rd_tick = &cnt_r;
endmodule : erab_fabric_model

// *** bench/erab_top_tb_top.sv ***
// Purpose: Self-checking bench for erab_top
// Assumes: Ticks from erab_fabric_model
// Notes:   Registers over AXI4-Lite
`timescale 1ns/1ps
module erab_top_tb_top;
   // =====
   // Bench
   logic        ref_clk = 1'b0, reset_n = 1'b0, clear_n = 1'b1, wr_en = 1'b0, rd_en = 1'b1;
   logic        wr_clk_en = 1'b1, rd_clk_en = 1'b1, wr_tick, rd_tick;
   logic [7:0]  wr_addr = 8'h0, rd_addr = 8'h0, s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [15:0] wr_data = 16'h0, rd_data;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int          n_tests = 0, n_mismatch = 0;
   erab_top i_erab_top (
      .ref_clk       (ref_clk),
      .reset_n       (reset_n),
      .clear_n       (clear_n),
      .wr_tick       (wr_tick),
      .wr_clk_en     (wr_clk_en),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .rd_tick       (rd_tick),
      .rd_clk_en     (rd_clk_en),
      .rd_en         (rd_en),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready)
   );
   erab_fabric_model i_erab_fabric_model (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .wr_tick (wr_tick),
      .rd_tick (rd_tick)
   );
   always #12.5 ref_clk = ~ref_clk;
   task cmp(input logic [33:0] g, input logic [33:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task cmpw(input logic [15:0] e);
      cmp({18'h0, rd_data}, {18'h0, e});
   endtask : cmpw
   task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ta;
      logic tw;
      @(posedge ref_clk);
      ta = 1'b0;
      tw = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw))
      begin
         @(negedge ref_clk);
         ta = ta || s_axi_awready;
         tw = tw || s_axi_wready;
         @(posedge ref_clk);
         s_axi_awvalid <= !ta;
         s_axi_wvalid <= !tw;
      end
      do @(negedge ref_clk); while (!s_axi_bvalid);
      cmp({32'h0, s_axi_bresp}, {32'h0, r});
      @(posedge ref_clk);
      s_axi_bready <= 1'b0;
   endtask : axw
   task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge ref_clk); while (!s_axi_arready);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge ref_clk); while (!s_axi_rvalid);
      cmp({s_axi_rresp, s_axi_rdata}, {r, d});
      @(posedge ref_clk);
      s_axi_rready <= 1'b0;
   endtask : axr
   task usr(input logic w, input logic [7:0] wa, input logic [15:0] wd, input logic [7:0] ra);
      @(posedge ref_clk);
      wr_en <= w;
      wr_addr <= wa;
      wr_data <= wd;
      rd_addr <= ra;
      repeat (3) @(posedge ref_clk iff rd_tick);
      @(negedge ref_clk);
   endtask : usr
   task end_of_test();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      n_mismatch++;
      end_of_test();
   end
   initial
   begin
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      axr(8'h00, 32'h0f00, 2'h0);
      axr(8'h10, 32'h0, 2'h2);
      axw(8'h0c, 32'h1, 2'h2);
      axw(8'h04, 32'h5, 2'h0);
      axw(8'h08, 32'h1234, 2'h0);
      axw(8'h08, 32'habcd, 2'h0);
      axr(8'h04, 32'h7, 2'h0);
      axw(8'h04, 32'h6, 2'h0);
      axr(8'h08, 32'habcd, 2'h0);
      axw(8'h00, 32'h0f09, 2'h0);
      usr(1'b1, 8'h05, 16'h0, 8'h06);
      cmpw(16'habcd);
      usr(1'b0, 8'h05, 16'h0, 8'h05);
      cmpw(16'h1234);
      axw(8'h00, 32'h0f01, 2'h0);
      usr(1'b1, 8'h07, 16'h5a5a, 8'h07);
      cmpw(16'h5a5a);
      axr(8'h0c, 32'h5a5a, 2'h0);
      rd_clk_en <= 1'b0;
      usr(1'b0, 8'h07, 16'h0, 8'h05);
      cmpw(16'h5a5a);
      @(posedge ref_clk);
      rd_clk_en <= 1'b1;
      wr_clk_en <= 1'b0;
      usr(1'b1, 8'h07, 16'h1111, 8'h07);
      cmpw(16'h5a5a);
      @(posedge ref_clk);
      wr_en <= 1'b0;
      wr_clk_en <= 1'b1;
      axw(8'h00, 32'h0701, 2'h0);
      usr(1'b1, 8'h08, 16'hffff, 8'h08);
      cmpw(16'h00ff);
      axw(8'h00, 32'h0f07, 2'h0);
      @(posedge ref_clk);
      rd_addr <= 8'h06;
      @(negedge ref_clk);
      cmpw(16'habcd);
      axw(8'h00, 32'h0f00, 2'h0);
      usr(1'b0, 8'h05, 16'h0, 8'h00);
      cmpw(16'h1234);
      @(posedge ref_clk);
      rd_en <= 1'b0;
      usr(1'b0, 8'h08, 16'h0, 8'h00);
      cmpw(16'h1234);
      @(posedge ref_clk);
      clear_n <= 1'b0;
      @(negedge ref_clk);
      cmpw(16'h0);
      end_of_test();
   end
endmodule : erab_top_tb_top
